// File: logic/tcw_pkg.sv
package tcw_pkg;
    // Counter range
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_STEP = 8'h01;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    // Clock select value that stops the counter
    localparam logic [2:0] CS_STOP = 3'h0;
    // Waveform mode encodings; 4 and 6 behave as normal mode
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PHASE_MAX = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PHASE_CMP = 3'h5;
    localparam logic [2:0] WM_FAST_CMP = 3'h7;
    // Output action encodings
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Channel index of the pin groups
    localparam int CH_A = 0;
    localparam int CH_B = 1;

    typedef enum logic [3:0] {
        MC_NORMAL = 4'h1,
        MC_CTC = 4'h2,
        MC_FAST = 4'h4,
        MC_PHASE = 4'h8
    } tcw_class_e;

    typedef struct packed {
        logic [1:0] action;
        logic force_strobe;
    } tcw_chan_cfg_s;

    typedef struct packed {
        logic match_ev;
        logic bottom_ev;
        logic down;
        logic alt_toggle;
    } tcw_wave_ev_s;

    typedef struct packed {
        logic ovf;
        logic mat_b;
        logic mat_a;
    } tcw_flags_s;
endpackage

// File: logic/tcw_compare_unit.sv
`timescale 1ns/1ns
module tcw_compare_unit import tcw_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Buffer control
    input wire logic buffered,
    input wire logic load,
    // Software write
    input wire logic wr,
    input wire logic [7:0] wr_data,
    // Counter side
    input wire logic [7:0] count,
    input wire logic tick,
    input wire logic block,
    input wire logic flag_clr,
    // Results
    output logic [7:0] value_r,
    output logic [7:0] active_r,
    output logic match,
    output logic match_ev,
    output logic flag_r
);
    // Buffer register, the one software reads and writes
    always_ff @(posedge clock) begin
        if (srst) begin
            value_r <= CMP_RESET;
        end else if (wr) begin
            value_r <= wr_data;
        end
    end

    // Active register, written directly unless buffered
    always_ff @(posedge clock) begin
        if (srst) begin
            active_r <= CMP_RESET;
        end else if (wr && !buffered) begin
            active_r <= wr_data;
        end else if (load && buffered) begin
            active_r <= value_r;
        end
    end

    assign match = (count == active_r);
    assign match_ev = tick && match && !block;

    // Set wins over clear
    always_ff @(posedge clock) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else if (match_ev) begin
            flag_r <= 1'b1;
        end else if (flag_clr) begin
            flag_r <= 1'b0;
        end
    end
endmodule

// File: logic/tcw_wave_pin.sv
`timescale 1ns/1ns
module tcw_wave_pin import tcw_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Mode and events
    input wire tcw_class_e cls,
    input wire tcw_chan_cfg_s cfg,
    input wire tcw_wave_ev_s ev,
    // Port side
    input wire logic port_out,
    input wire logic pin_dir,
    output logic wave_r,
    output logic pin_o,
    output logic pin_oe_n
);
    logic wave_nxt;

    always_comb begin
        wave_nxt = wave_r;
        case (cls)
            MC_FAST: begin
                if (ev.match_ev) begin
                    if (cfg.action == ACT_TOGGLE && ev.alt_toggle) begin
                        wave_nxt = !wave_r;
                    end else if (cfg.action == ACT_CLEAR) begin
                        wave_nxt = 1'b0;
                    end else if (cfg.action == ACT_SET) begin
                        wave_nxt = 1'b1;
                    end
                end else if (ev.bottom_ev) begin
                    if (cfg.action == ACT_CLEAR) begin
                        wave_nxt = 1'b1;
                    end else if (cfg.action == ACT_SET) begin
                        wave_nxt = 1'b0;
                    end
                end
            end
            MC_PHASE: begin
                if (ev.match_ev) begin
                    if (cfg.action == ACT_TOGGLE && ev.alt_toggle) begin
                        wave_nxt = !wave_r;
                    end else if (cfg.action == ACT_CLEAR) begin
                        wave_nxt = ev.down;
                    end else if (cfg.action == ACT_SET) begin
                        wave_nxt = !ev.down;
                    end
                end
            end
            default: begin
                // Non-PWM: real or forced match acts alike
                if (ev.match_ev || cfg.force_strobe) begin
                    case (cfg.action)
                        ACT_TOGGLE: wave_nxt = !wave_r;
                        ACT_CLEAR: wave_nxt = 1'b0;
                        ACT_SET: wave_nxt = 1'b1;
                        default: wave_nxt = wave_r;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wave_r <= 1'b0;
        end else begin
            wave_r <= wave_nxt;
        end
    end

    assign pin_o = (cfg.action != ACT_NONE) ? wave_r : port_out;
    assign pin_oe_n = !pin_dir;
endmodule

// File: logic/tcw_timer.sv
`timescale 1ns/1ns
module tcw_timer import tcw_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Tick source
    input wire logic [2:0] clock_select_field,
    input wire logic [7:0] source_ticks,
    // Mode bits
    input wire logic wave_mode_bit0,
    input wire logic wave_mode_bit1,
    input wire logic wave_mode_bit2,
    // Counter access
    input wire logic count_wr,
    input wire logic [7:0] count_wr_data,
    output logic [7:0] count_value,
    // Compare access
    input wire logic cmp_wr_a,
    input wire logic cmp_wr_b,
    input wire logic [7:0] cmp_wr_data,
    output logic [7:0] compare_value_a,
    output logic [7:0] compare_value_b,
    // Flags and interrupts
    input wire tcw_flags_s flag_clear,
    input wire tcw_flags_s irq_ack,
    input wire tcw_flags_s irq_enable,
    output logic overflow_flag,
    output logic match_flag_a,
    output logic match_flag_b,
    output tcw_flags_s irq_req,
    // Counter status
    output logic at_top,
    output logic at_bottom,
    output logic count_down,
    // Output channels
    input wire tcw_chan_cfg_s cfg_a,
    input wire tcw_chan_cfg_s cfg_b,
    input wire logic [1:0] port_out,
    input wire logic [1:0] wave_pin_direction,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic [1:0] wave_pin_o,
    output logic [1:0] wave_pin_oe_n
);
    logic [2:0] wave_mode_field;
    tcw_class_e cls;
    logic timer_tick;
    logic cmp_top;
    logic [7:0] top_val;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic dir_r;
    logic dir_nxt;
    logic ovf_set;
    logic ovf_r;
    logic block_r;
    logic buffered;
    logic load;
    logic non_pwm;
    logic [7:0] active_a;
    logic [7:0] active_b;
    logic match_a;
    logic match_b;
    logic mev_a;
    logic mev_b;
    tcw_chan_cfg_s gcfg_a;
    tcw_chan_cfg_s gcfg_b;
    tcw_wave_ev_s ev_a;
    tcw_wave_ev_s ev_b;

    assign wave_mode_field = {wave_mode_bit2, wave_mode_bit1, wave_mode_bit0};

    always_comb begin
        case (wave_mode_field)
            WM_CTC: cls = MC_CTC;
            WM_FAST_MAX, WM_FAST_CMP: cls = MC_FAST;
            WM_PHASE_MAX, WM_PHASE_CMP: cls = MC_PHASE;
            default: cls = MC_NORMAL;
        endcase
    end

    assign timer_tick = (clock_select_field != CS_STOP) && source_ticks[clock_select_field];

    assign cmp_top = (wave_mode_field == WM_FAST_CMP) || (wave_mode_field == WM_PHASE_CMP) || (cls == MC_CTC);
    assign top_val = cmp_top ? active_a : CNT_MAX;
    assign at_top = (count_r == top_val);
    assign at_bottom = (count_r == CNT_BOTTOM);
    assign count_down = dir_r;
    assign count_value = count_r;

    // Next count and direction per mode
    always_comb begin
        count_nxt = count_r;
        dir_nxt = dir_r;
        ovf_set = 1'b0;
        if (timer_tick) begin
            case (cls)
                MC_CTC: begin
                    count_nxt = match_a ? CNT_BOTTOM : count_r + CNT_STEP;
                    ovf_set = (count_r == CNT_MAX);
                end
                MC_FAST: begin
                    count_nxt = at_top ? CNT_BOTTOM : count_r + CNT_STEP;
                    ovf_set = at_top;
                end
                MC_PHASE: begin
                    if (dir_r) begin
                        if (at_bottom) begin
                            dir_nxt = 1'b0;
                            count_nxt = count_r + CNT_STEP;
                            ovf_set = 1'b1;
                        end else begin
                            count_nxt = count_r - CNT_STEP;
                        end
                    end else if (at_top) begin
                        dir_nxt = 1'b1;
                        count_nxt = count_r - CNT_STEP;
                    end else begin
                        count_nxt = count_r + CNT_STEP;
                    end
                end
                default: begin
                    count_nxt = count_r + CNT_STEP;
                    ovf_set = (count_r == CNT_MAX);
                end
            endcase
        end
        if (count_wr) begin
            count_nxt = count_wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            count_r <= CNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Direction only matters in phase correct mode
    always_ff @(posedge clock) begin
        if (srst || cls != MC_PHASE) begin
            dir_r <= 1'b0;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // Match blocking window after a count write
    always_ff @(posedge clock) begin
        if (srst) begin
            block_r <= 1'b0;
        end else if (count_wr) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clock) begin
        if (srst) begin
            ovf_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_r <= 1'b1;
        end else if (flag_clear.ovf || irq_ack.ovf) begin
            ovf_r <= 1'b0;
        end
    end

    assign overflow_flag = ovf_r;
    assign non_pwm = (cls == MC_NORMAL) || (cls == MC_CTC);
    assign buffered = !non_pwm;
    assign load = buffered && timer_tick && at_top;

    tcw_compare_unit u_cmp_a (
        .clock(clock),
        .srst(srst),
        .buffered(buffered),
        .load(load),
        .wr(cmp_wr_a),
        .wr_data(cmp_wr_data),
        .count(count_r),
        .tick(timer_tick),
        .block(block_r),
        .flag_clr(flag_clear.mat_a || irq_ack.mat_a),
        .value_r(compare_value_a),
        .active_r(active_a),
        .match(match_a),
        .match_ev(mev_a),
        .flag_r(match_flag_a)
    );

    tcw_compare_unit u_cmp_b (
        .clock(clock),
        .srst(srst),
        .buffered(buffered),
        .load(load),
        .wr(cmp_wr_b),
        .wr_data(cmp_wr_data),
        .count(count_r),
        .tick(timer_tick),
        .block(block_r),
        .flag_clr(flag_clear.mat_b || irq_ack.mat_b),
        .value_r(compare_value_b),
        .active_r(active_b),
        .match(match_b),
        .match_ev(mev_b),
        .flag_r(match_flag_b)
    );

    assign irq_req.ovf = ovf_r && irq_enable.ovf;
    assign irq_req.mat_a = match_flag_a && irq_enable.mat_a;
    assign irq_req.mat_b = match_flag_b && irq_enable.mat_b;

    // Force strobes only count in non-PWM modes
    always_comb begin
        gcfg_a = cfg_a;
        gcfg_b = cfg_b;
        gcfg_a.force_strobe = cfg_a.force_strobe && non_pwm;
        gcfg_b.force_strobe = cfg_b.force_strobe && non_pwm;
    end

    // Toggle in PWM modes exists on channel A only, with the high mode bit
    always_comb begin
        ev_a.match_ev = mev_a;
        ev_a.bottom_ev = timer_tick && at_top && !count_wr && (cls == MC_FAST);
        ev_a.down = dir_r;
        ev_a.alt_toggle = wave_mode_bit2;
        ev_b = ev_a;
        ev_b.match_ev = mev_b;
        ev_b.alt_toggle = 1'b0;
    end

    tcw_wave_pin u_pin_a (
        .clock(clock),
        .srst(srst),
        .cls(cls),
        .cfg(gcfg_a),
        .ev(ev_a),
        .port_out(port_out[CH_A]),
        .pin_dir(wave_pin_direction[CH_A]),
        .wave_r(wave_out_a),
        .pin_o(wave_pin_o[CH_A]),
        .pin_oe_n(wave_pin_oe_n[CH_A])
    );

    tcw_wave_pin u_pin_b (
        .clock(clock),
        .srst(srst),
        .cls(cls),
        .cfg(gcfg_b),
        .ev(ev_b),
        .port_out(port_out[CH_B]),
        .pin_dir(wave_pin_direction[CH_B]),
        .wave_r(wave_out_b),
        .pin_o(wave_pin_o[CH_B]),
        .pin_oe_n(wave_pin_oe_n[CH_B])
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence count_write_s;
        count_wr;
    endsequence

    sequence ctc_top_tick_s;
        timer_tick && cls == MC_CTC && match_a && !count_wr;
    endsequence

    sequence blocked_tick_s;
        block_r && timer_tick && !count_wr;
    endsequence

    sequence idle_match_a_s;
        timer_tick && match_a && !block_r && cfg_a.action == ACT_NONE;
    endsequence

    bottom_flag_a: assert property (timer_tick && cls == MC_NORMAL && count_r == CNT_MAX && !count_wr |=> at_bottom)
        else $error("bottom status wrong");

    normal_step_a: assert property (timer_tick && cls == MC_NORMAL && !count_wr
        |=> count_value == $past(count_value) + CNT_STEP)
        else $error("normal mode step wrong");

    stop_hold_a: assert property ((clock_select_field == CS_STOP && !count_wr) [*2]
        |-> $stable(count_value))
        else $error("counter moved while stopped");

    write_prio_a: assert property (count_write_s |=> count_value == $past(count_wr_data))
        else $error("count write lost");

    ctc_clear_a: assert property (ctc_top_tick_s |=> count_value == CNT_BOTTOM)
        else $error("ctc did not clear at compare A");

    ovf_normal_a: assert property (timer_tick && cls == MC_NORMAL && count_r == CNT_MAX
        |=> overflow_flag && count_value == CNT_BOTTOM || $past(count_wr))
        else $error("overflow missed");

    match_out_a: assert property (timer_tick && count_r == active_b && !block_r |=> match_flag_b)
        else $error("compare B match wrong");

    flag_next_a: assert property (timer_tick && match_a && !block_r |=> match_flag_a)
        else $error("compare A flag not set");

    flag_clear_a: assert property (flag_clear.mat_b && !mev_b |=> !match_flag_b ##0 !irq_req.mat_b)
        else $error("compare B flag not cleared");

    pwm_buffer_a: assert property (buffered && cmp_wr_a && !load |=> $stable(active_a))
        else $error("active compare changed without load");

    direct_write_a: assert property (!buffered && cmp_wr_b |=> active_b == $past(cmp_wr_data))
        else $error("direct compare write lost");

    force_noflag_a: assert property (cfg_a.force_strobe && !mev_a && !match_flag_a
        |=> !match_flag_a && $stable(count_value) || $past(timer_tick || count_wr))
        else $error("force strobe touched flag or count");

    write_block_a: assert property (blocked_tick_s ##0 !match_flag_a |=> !match_flag_a)
        else $error("match not blocked after count write");

    mode_keep_a: assert property ($changed(wave_mode_field) && !mev_a && !cfg_a.force_strobe
        && !(timer_tick && at_top) |=> $stable(wave_out_a))
        else $error("wave output changed on mode change");

    reset_wave_a: assert property (@(posedge clock) disable iff (1'b0)
        srst |=> !wave_out_a && !wave_out_b)
        else $error("wave outputs not cleared by reset");

    override_a: assert property (cfg_b.action != ACT_NONE |-> wave_pin_o[CH_B] == wave_out_b)
        else $error("port value not overridden");

    pin_drive_a: assert property (wave_pin_oe_n[CH_A] == !wave_pin_direction[CH_A])
        else $error("pin enable does not follow direction");

    no_action_a: assert property (idle_match_a_s ##0 non_pwm |=> $stable(wave_out_a))
        else $error("wave output changed with no action");

    action_now_a: assert property (non_pwm && mev_a && cfg_a.action == ACT_SET
        && $changed(cfg_a.action) |=> wave_out_a)
        else $error("new action not applied at first match");
endmodule

// File: testbench/tcw_cpu_model.sv
`timescale 1ns/1ns
module tcw_cpu_model import tcw_pkg::*; (
    // Clock and view of the timer
    input wire logic clock,
    input wire logic [2:0] mode,
    input wire logic [7:0] count_value,
    input wire logic [7:0] compare_value_a,
    input wire logic [7:0] compare_value_b,
    // Programmed controls
    output logic [2:0] clock_select_field,
    output logic [7:0] source_ticks,
    output logic count_wr,
    output logic cmp_wr_a,
    output logic cmp_wr_b,
    output logic [7:0] wr_data,
    output tcw_flags_s flag_clear,
    output tcw_flags_s irq_ack,
    output tcw_flags_s irq_enable,
    output tcw_chan_cfg_s cfg_a,
    output tcw_chan_cfg_s cfg_b,
    output logic [1:0] port_out,
    output logic [1:0] wave_pin_direction
);
    int seed = 78;
    int n = 0;
    logic [2:0] cs;
    logic [7:0] st;
    logic [1:0] ra = 2'h0;
    logic [1:0] rb = 2'h0;
    logic tk;
    logic pwm;
    logic safe;
    initial begin
        {clock_select_field, source_ticks, count_wr, cmp_wr_a, cmp_wr_b, wr_data} = '0;
        {flag_clear, irq_ack, irq_enable, cfg_a, cfg_b, port_out, wave_pin_direction} = '0;
    end
    always @(negedge clock) begin
        n = n + 1;
        pwm = mode == WM_FAST_MAX;
        cs = (n % 64 == 0) ? 3'($random(seed)) : clock_select_field;
        st = 8'($random(seed));
        tk = cs != CS_STOP && st[cs];
        // A write on a tick only where no match can hide behind it
        safe = mode == WM_NORMAL && count_value != compare_value_a && count_value != compare_value_b;
        clock_select_field <= cs;
        source_ticks <= st;
        count_wr <= ($random(seed) % 16 == 0) && (!tk || safe);
        cmp_wr_a <= ($random(seed) % 24 == 0) && !tk;
        cmp_wr_b <= ($random(seed) % 24 == 0) && !tk;
        wr_data <= 8'($unsigned($random(seed)) % 255);
        flag_clear <= ($random(seed) % 12 == 0) ? 3'($random(seed)) : 3'h0;
        irq_ack <= ($random(seed) % 12 == 0) ? 3'($random(seed)) : 3'h0;
        port_out <= 2'($random(seed));
        cfg_a.force_strobe <= ($random(seed) % 8 == 0) && !tk;
        cfg_b.force_strobe <= ($random(seed) % 8 == 0) && !tk;
        cfg_a.action <= (pwm && ra == ACT_TOGGLE) ? ACT_CLEAR : ra;
        cfg_b.action <= (pwm && rb == ACT_TOGGLE) ? ACT_CLEAR : rb;
        if (n % 64 == 0) begin
            irq_enable <= 3'($random(seed));
            ra = 2'($random(seed));
            rb = 2'($random(seed));
            // Pins stay inputs for the first 256 cycles
            wave_pin_direction <= (n < 256) ? 2'h0 : 2'($random(seed));
        end
    end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ns
module testbench import tcw_pkg::*; ();
    logic clock = 0;
    logic srst = 1;
    logic [2:0] md = WM_NORMAL;
    logic [2:0] modes [5] = '{WM_NORMAL, WM_CTC, 3'h6, WM_FAST_MAX, WM_PHASE_MAX};
    logic [2:0] cs;
    logic [7:0] st, wd, cv, ca, cb;
    logic cnt_wr, cwa, cwb, ovf, mfa, mfb, top, bot, dn, wa, wb;
    tcw_flags_s fclr, ack, ien, irq;
    tcw_chan_cfg_s cfa, cfb;
    logic [1:0] pout, pdir, po, poe;
    int m_cnt, m_blk, c;
    int m_act[2];
    int m_buf[2];
    logic [2:0] m_flg, m_hit;
    logic [1:0] m_wav, a;
    logic tk, pw, m_dir;
    logic go = 0;
    int n_fail = 0;
    int checks = 0;

    tcw_timer dut (.clock(clock), .srst(srst), .clock_select_field(cs), .source_ticks(st),
        .wave_mode_bit0(md[0]), .wave_mode_bit1(md[1]), .wave_mode_bit2(md[2]), .count_wr(cnt_wr),
        .count_wr_data(wd), .count_value(cv), .cmp_wr_a(cwa), .cmp_wr_b(cwb), .cmp_wr_data(wd),
        .compare_value_a(ca), .compare_value_b(cb), .flag_clear(fclr), .irq_ack(ack), .irq_enable(ien),
        .overflow_flag(ovf), .match_flag_a(mfa), .match_flag_b(mfb), .irq_req(irq), .at_top(top),
        .at_bottom(bot), .count_down(dn), .cfg_a(cfa), .cfg_b(cfb), .port_out(pout),
        .wave_pin_direction(pdir), .wave_out_a(wa), .wave_out_b(wb), .wave_pin_o(po), .wave_pin_oe_n(poe));

    tcw_cpu_model cpu (.clock(clock), .mode(md), .count_value(cv), .compare_value_a(ca),
        .compare_value_b(cb), .clock_select_field(cs), .source_ticks(st), .count_wr(cnt_wr),
        .cmp_wr_a(cwa), .cmp_wr_b(cwb), .wr_data(wd), .flag_clear(fclr), .irq_ack(ack),
        .irq_enable(ien), .cfg_a(cfa), .cfg_b(cfb), .port_out(pout), .wave_pin_direction(pdir));

    task automatic chk_val(input logic [7:0] got, input int exp);
        checks++;
        if (got !== 8'(exp)) begin
            n_fail++;
            $display("FAIL %0t value %0h expected %0h", $time, got, 8'(exp));
        end
    endtask

    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t bits %b expected %b", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always #20 clock = ~clock;

    // Reference model, one step per rising clock edge
    always @(posedge clock) begin
        if (srst) begin
            m_cnt = 0;
            m_blk = 0;
            m_dir = 0;
            m_flg = 0;
            m_wav = 0;
            m_act = '{0, 0};
            m_buf = '{0, 0};
        end else begin
            tk = cs != CS_STOP && st[cs];
            pw = md == WM_FAST_MAX || md == WM_PHASE_MAX;
            m_hit = 0;
            for (c = 0; c < 2; c++) begin
                a = c ? cfb.action : cfa.action;
                m_hit[c] = tk && m_cnt == m_act[c] && m_blk == 0;
                if (pw) begin
                    // A match beats the fast mode bottom event in the same cycle
                    if (md == WM_FAST_MAX && tk && m_cnt == 255 && !cnt_wr && a > 1) m_wav[c] = !a[0];
                    if (m_hit[c] && a > 1) m_wav[c] = a[0] ^ m_dir;
                end else if (m_hit[c] || (c ? cfb.force_strobe : cfa.force_strobe)) begin
                    if (a == ACT_TOGGLE) m_wav[c] = !m_wav[c];
                    if (a > 1) m_wav[c] = a[0];
                end
            end
            m_hit[2] = tk && (md == WM_PHASE_MAX ? m_dir && m_cnt == 0 : m_cnt == 255);
            m_flg = m_flg & ~(fclr | ack) | m_hit;
            // Buffered compare values load on the tick taken at top
            if (pw && tk && m_cnt == 255) m_act = m_buf;
            if (tk) begin
                m_blk = 0;
                if (md != WM_PHASE_MAX) begin
                    m_cnt = (md == WM_CTC && m_cnt == m_act[0]) ? 0 : (m_cnt + 1) % 256;
                end else begin
                    if (m_cnt == (m_dir ? 0 : 255)) m_dir = !m_dir;
                    m_cnt = m_dir ? m_cnt - 1 : m_cnt + 1;
                end
            end
            if (md != WM_PHASE_MAX) m_dir = 0;
            if (cnt_wr) begin
                m_cnt = wd;
                m_blk = 1;
            end
            if (cwa) m_buf[0] = wd;
            if (cwb) m_buf[1] = wd;
            if (!pw) m_act = m_buf;
        end
    end

    // Compare every result while inputs are settled
    always @(negedge clock) begin
        if (go) begin
            chk_val(cv, m_cnt);
            chk_val(ca, m_buf[0]);
            chk_val(cb, m_buf[1]);
            chk_bits({ovf, mfb, mfa}, m_flg);
            chk_bits(irq, m_flg & ien);
            chk_bits({wb, wa}, m_wav);
            chk_bits(po, {cfb.action != 0 ? m_wav[1] : pout[1], cfa.action != 0 ? m_wav[0] : pout[0]});
            chk_bits(poe, {~pdir});
            chk_bits({top, bot, dn}, {m_cnt == (md == WM_CTC ? m_act[0] : 255), m_cnt == 0, m_dir});
        end
    end

    initial begin
        #(9000 * 40);
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        srst <= 0;
        go = 1;
        foreach (modes[i]) begin
            md <= modes[i];
            repeat (1500) @(negedge clock);
            if (i == 1) begin
                srst <= 1;
                repeat (2) @(negedge clock);
                srst <= 0;
            end
        end
        report_and_stop();
    end
endmodule
